// File: hdl/ivc_pkg.sv
package ivc_pkg;

  // ---------------------------------------------------------------
  // Vector addresses (one program word each)
  // ---------------------------------------------------------------
  localparam int unsigned    VEC_W                  = 5;
  localparam int unsigned    NUM_VEC                = 19;
  localparam logic [4:0]     RESET_VECTOR           = 5'h00;
  localparam logic [4:0]     EXT_LINE0_VECTOR       = 5'h01;
  localparam logic [4:0]     PIN_CHANGE_VECTOR      = 5'h02;
  localparam logic [4:0]     T1_MATCH_A_VECTOR      = 5'h03;
  localparam logic [4:0]     T1_MATCH_B_VECTOR      = 5'h04;
  localparam logic [4:0]     T1_OVERFLOW_VECTOR     = 5'h05;
  localparam logic [4:0]     T0_OVERFLOW_VECTOR     = 5'h06;
  localparam logic [4:0]     SERIAL_START_VECTOR    = 5'h07;
  localparam logic [4:0]     SERIAL_OVERFLOW_VECTOR = 5'h08;
  localparam logic [4:0]     NVM_READY_VECTOR       = 5'h09;
  localparam logic [4:0]     COMPARATOR_VECTOR      = 5'h0A;
  localparam logic [4:0]     CONVERTER_VECTOR       = 5'h0B;
  localparam logic [4:0]     WATCHDOG_VECTOR        = 5'h0C;
  localparam logic [4:0]     EXT_LINE1_VECTOR       = 5'h0D;
  localparam logic [4:0]     T0_MATCH_A_VECTOR      = 5'h0E;
  localparam logic [4:0]     T0_MATCH_B_VECTOR      = 5'h0F;
  localparam logic [4:0]     T0_CAPTURE_VECTOR      = 5'h10;
  localparam logic [4:0]     T1_MATCH_D_VECTOR      = 5'h11;
  localparam logic [4:0]     T1_FAULT_VECTOR        = 5'h12;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned    ADDR_W                 = 8;
  localparam logic [7:0]     MCU_CONTROL_OFS        = 8'h00;
  localparam logic [7:0]     PIN_CHANGE_MASK_OFS    = 8'h04;
  localparam logic [7:0]     IRQ_ENABLE_OFS         = 8'h08;
  localparam logic [7:0]     IRQ_FLAG_OFS           = 8'h0C;
  localparam logic [7:0]     IRQ_STATUS_OFS         = 8'h10;

  // Fields of the MCU control register
  localparam int unsigned    SENSE0_LSB             = 0;
  localparam int unsigned    SENSE1_LSB             = 2;
  // Fields of the status register
  localparam int unsigned    STAT_VEC_LSB           = 0;
  localparam int unsigned    STAT_REQ_BIT           = 5;
  localparam int unsigned    STAT_LINE0_BIT         = 6;
  localparam int unsigned    STAT_LINE1_BIT         = 7;

  // Reset values
  localparam logic [3:0]     MCU_CONTROL_RST        = 4'h0;
  localparam logic [15:0]    PIN_CHANGE_MASK_RST    = 16'h0000;
  localparam logic [18:0]    IRQ_ENABLE_RST         = 19'h00000;

  // AXI responses
  localparam logic [1:0]     RESP_OKAY              = 2'h0;
  localparam logic [1:0]     RESP_SLVERR            = 2'h2;

  // Sense control for the two external lines
  typedef enum logic [1:0] {
    SENSE_LOW     = 2'h0,
    SENSE_ANY     = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING  = 2'h3
  } ivc_sense_t;

endpackage

// File: hdl/ivc_top.sv
`timescale 1ns/10ps
module ivc_top (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [ivc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ivc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        ext_irq_line0,
  input  wire logic                        ext_irq_line1,
  input  wire logic [15:0]                 pin_change_sources,
  input  wire logic [13:0]                 periph_event,
  input  wire logic                        nvm_ready,
  input  wire logic                        cpu_global_ie,
  input  wire logic                        irq_ack,
  output logic                             irq_req,
  output logic [ivc_pkg::VEC_W-1:0]        irq_vector
);
  import ivc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pads are sampled whatever the pin direction, so driving a pin from
  // software raises its interrupt. Low-level and pin-change wake are
  // modelled on mclk here; the clockless wake path lives in the pad ring.
  logic [17:0] pin_meta;
  logic [17:0] pin_sync;
  logic [17:0] pin_prev;
  logic [17:0] next_pin_meta;
  logic [17:0] next_pin_sync;
  logic [17:0] next_pin_prev;

  always_comb begin
    next_pin_meta = pin_meta;
    next_pin_sync = pin_sync;
    next_pin_prev = pin_prev;
    if (ce) begin
      next_pin_meta = {ext_irq_line1, ext_irq_line0, pin_change_sources};
      next_pin_sync = pin_meta;
      next_pin_prev = pin_sync;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= '1;
      pin_sync <= '1;
      pin_prev <= '1;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0]       mcu_control_reg;
  logic [15:0]      pin_change_mask_reg;
  logic [18:0]      irq_enable;
  logic [18:0]      irq_flag;
  logic [3:0]       next_mcu_control_reg;
  logic [15:0]      next_pin_change_mask_reg;
  logic [18:0]      next_irq_enable;
  logic [18:0]      next_irq_flag;

  ivc_sense_t       sense0;
  ivc_sense_t       sense1;
  logic             line0_now;
  logic             line1_now;
  logic             line0_edge;
  logic             line1_edge;
  logic             pc_toggle;
  logic [18:0]      ev_set;
  logic [18:0]      lvl_req;
  logic [18:0]      pending;
  logic [18:0]      sw_clear;
  logic [18:0]      ack_clear;

  assign sense0    = ivc_sense_t'(mcu_control_reg[SENSE0_LSB +: 2]);
  assign sense1    = ivc_sense_t'(mcu_control_reg[SENSE1_LSB +: 2]);
  assign line0_now = pin_sync[16];
  assign line1_now = pin_sync[17];

  // Edge detection runs on mclk only and so is dead while it stops
  function automatic logic edge_hit(input ivc_sense_t s, input logic now,
                                    input logic prev);
    case (s)
      SENSE_ANY:     edge_hit = now ^ prev;
      SENSE_FALLING: edge_hit = prev & ~now;
      SENSE_RISING:  edge_hit = now & ~prev;
      default:       edge_hit = 1'b0;
    endcase
  endfunction

  assign line0_edge = edge_hit(sense0, line0_now, pin_prev[16]);
  assign line1_edge = edge_hit(sense1, line1_now, pin_prev[17]);
  assign pc_toggle  = |((pin_sync[15:0] ^ pin_prev[15:0]) & pin_change_mask_reg);

  // Event sources, indexed by vector address
  assign ev_set = {periph_event[13:9], line1_edge, periph_event[8:6], 1'b0,
                   periph_event[5:0], pc_toggle, line0_edge, 1'b0};

  // Level sources are requested live, never latched
  always_comb begin
    lvl_req                   = '0;
    lvl_req[EXT_LINE0_VECTOR] = (sense0 == SENSE_LOW) & ~line0_now;
    lvl_req[EXT_LINE1_VECTOR] = (sense1 == SENSE_LOW) & ~line1_now;
    lvl_req[NVM_READY_VECTOR] = nvm_ready;
  end

  assign pending = (irq_flag | lvl_req) & irq_enable & {NUM_VEC{cpu_global_ie}};

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic             wr_take;
  logic             rd_take;
  logic             next_awready;
  logic             next_wready;
  logic             next_bvalid;
  logic [1:0]       next_bresp;
  logic             next_arready;
  logic             next_rvalid;
  logic [31:0]      next_rdata;
  logic [1:0]       next_rresp;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             wr_hit;
  logic             wr_low;

  // Address and data are taken together, so a lone channel simply waits
  assign wr_take = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wready;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign wr_low  = s_axi_wstrb[0];

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      MCU_CONTROL_OFS:     rd_word[3:0]  = mcu_control_reg;
      PIN_CHANGE_MASK_OFS: rd_word[15:0] = pin_change_mask_reg;
      IRQ_ENABLE_OFS:      rd_word[18:0] = irq_enable;
      IRQ_FLAG_OFS:        rd_word[18:0] = irq_flag | lvl_req;
      IRQ_STATUS_OFS: begin
        rd_word[STAT_VEC_LSB +: VEC_W] = irq_vector;
        rd_word[STAT_REQ_BIT]          = irq_req;
        rd_word[STAT_LINE0_BIT]        = line0_now;
        rd_word[STAT_LINE1_BIT]        = line1_now;
      end
      default:             rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (s_axi_awaddr)
      MCU_CONTROL_OFS, PIN_CHANGE_MASK_OFS, IRQ_ENABLE_OFS,
      IRQ_FLAG_OFS, IRQ_STATUS_OFS: wr_hit = 1'b1;
      default:                      wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_awready = 1'b0;
    next_wready  = 1'b0;
    next_bvalid  = s_axi_bvalid & ~s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid & ~s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid) begin
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
      next_arready = 1'b1;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // Control registers and request flags
  // ---------------------------------------------------------------
  always_comb begin
    next_mcu_control_reg     = mcu_control_reg;
    next_pin_change_mask_reg = pin_change_mask_reg;
    next_irq_enable          = irq_enable;
    sw_clear                 = '0;
    if (wr_take) begin
      case (s_axi_awaddr)
        MCU_CONTROL_OFS:
          if (wr_low) next_mcu_control_reg = s_axi_wdata[3:0];
        PIN_CHANGE_MASK_OFS: begin
          if (s_axi_wstrb[0]) next_pin_change_mask_reg[7:0]  = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) next_pin_change_mask_reg[15:8] = s_axi_wdata[15:8];
        end
        IRQ_ENABLE_OFS: begin
          if (s_axi_wstrb[0]) next_irq_enable[7:0]   = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) next_irq_enable[15:8]  = s_axi_wdata[15:8];
          if (s_axi_wstrb[2]) next_irq_enable[18:16] = s_axi_wdata[18:16];
          next_irq_enable[RESET_VECTOR] = 1'b0;
        end
        IRQ_FLAG_OFS: begin
          if (s_axi_wstrb[0]) sw_clear[7:0]   = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) sw_clear[15:8]  = s_axi_wdata[15:8];
          if (s_axi_wstrb[2]) sw_clear[18:16] = s_axi_wdata[18:16];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    ack_clear = '0;
    if (irq_ack & irq_req) begin
      ack_clear[irq_vector] = 1'b1;
    end
  end

  // A source firing in the clearing cycle keeps its flag set
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_flag
      assign next_irq_flag[gi] = ev_set[gi] |
                                 (irq_flag[gi] & ~(sw_clear[gi] | ack_clear[gi]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Vector selection towards the core
  // ---------------------------------------------------------------
  logic                 next_irq_req;
  logic [VEC_W-1:0]     next_irq_vector;
  logic [VEC_W-1:0]     best;

  always_comb begin
    best = RESET_VECTOR;
    for (int i = NUM_VEC - 1; i > 0; i--) begin
      if (pending[i]) best = VEC_W'(i);
    end
  end

  // Drop the request for one cycle after an ack so a stale vector is
  // never offered while the taken flag is still being cleared.
  always_comb begin
    next_irq_req    = (|pending) & ~irq_ack;
    next_irq_vector = (|pending) ? best : irq_vector;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mcu_control_reg     <= MCU_CONTROL_RST;
      pin_change_mask_reg <= PIN_CHANGE_MASK_RST;
      irq_enable          <= IRQ_ENABLE_RST;
      irq_flag            <= '0;
      irq_req             <= 1'b0;
      irq_vector          <= RESET_VECTOR;
      s_axi_awready       <= 1'b0;
      s_axi_wready        <= 1'b0;
      s_axi_bvalid        <= 1'b0;
      s_axi_bresp         <= RESP_OKAY;
      s_axi_arready       <= 1'b0;
      s_axi_rvalid        <= 1'b0;
      s_axi_rdata         <= '0;
      s_axi_rresp         <= RESP_OKAY;
    end else if (ce) begin
      mcu_control_reg     <= next_mcu_control_reg;
      pin_change_mask_reg <= next_pin_change_mask_reg;
      irq_enable          <= next_irq_enable;
      irq_flag            <= next_irq_flag;
      irq_req             <= next_irq_req;
      irq_vector          <= next_irq_vector;
      s_axi_awready       <= next_awready;
      s_axi_wready        <= next_wready;
      s_axi_bvalid        <= next_bvalid;
      s_axi_bresp         <= next_bresp;
      s_axi_arready       <= next_arready;
      s_axi_rvalid        <= next_rvalid;
      s_axi_rdata         <= next_rdata;
      s_axi_rresp         <= next_rresp;
    end
  end

endmodule

// File: test/ivc_top_sva.sv
`timescale 1ns/10ps
module ivc_top_sva
  import ivc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_global_ie,
  input wire logic        irq_ack,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_vector
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_drops_req: assert property (irq_ack && irq_req && ce |=> !irq_req)
    else $error("request still up after ack");
  a_vector_nonzero: assert property (irq_req |-> irq_vector != RESET_VECTOR)
    else $error("reset vector requested");
  a_vector_in_range: assert property (irq_req |-> irq_vector <= T1_FAULT_VECTOR)
    else $error("vector beyond last");
  a_global_gate: assert property (!cpu_global_ie && ce |=> !irq_req)
    else $error("request with global enable low");
  a_reset_idle: assert property ($fell(rst) |-> irq_vector == RESET_VECTOR && !irq_req)
    else $error("not idle after reset");
  a_write_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready apart");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_bresp_follows: assert property (s_axi_awready && s_axi_awvalid && ce |=> s_axi_bvalid)
    else $error("no write response");
  a_rdata_follows: assert property (s_axi_arready && s_axi_arvalid && ce |=> s_axi_rvalid)
    else $error("no read data");
  c_ack: cover property (irq_ack && irq_req);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind ivc_top ivc_top_sva u_sva (.mclk, .rst, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_global_ie, .irq_ack,
  .irq_req, .irq_vector);

// File: test/ivc_core_model.sv
`timescale 1ns/10ps
module ivc_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic [1:0] ack_wait,
  input  wire logic       irq_req,
  output logic            irq_ack
);
  // ---------------------------------------------------------------
  // Core taking vectors
  // ---------------------------------------------------------------
  logic [1:0] wait_cnt;
  // Ack only after the request stood ack_wait cycles, so slow cores are tried too
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 2'h0;
      irq_ack  <= 1'h0;
    end else begin
      irq_ack  <= irq_req && ack_en && !irq_ack && wait_cnt == ack_wait;
      wait_cnt <= (irq_req && !irq_ack && wait_cnt != ack_wait) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// File: test/ivc_top_bench.sv
`timescale 1ns/10ps
module ivc_top_bench;
  import ivc_pkg::*;
  // ---------------------------------------------------------------
  // Signals and notes
  // ---------------------------------------------------------------
  logic        mclk, rst, ce, ack_en, nvm_ready, cpu_global_ie, irq_ack, irq_req;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ext_irq_line0, ext_irq_line1;
  logic [1:0]  ack_wait, s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  irq_vector;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [13:0] periph_event;
  logic [15:0] pin_change_sources, pmask;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [4:0]  exp_v[$];
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  int          fails, total_checks;

  ivc_top DUT (.mclk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_irq_line0, .ext_irq_line1, .pin_change_sources, .periph_event,
    .nvm_ready, .cpu_global_ie, .irq_ack, .irq_req, .irq_vector);
  ivc_core_model core (.mclk, .rst, .ack_en, .ack_wait, .irq_req, .irq_ack);

  always #10 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] ev_vec(input int i);
    return (i < 6) ? 5'(i + 3) : (i < 9) ? 5'(i + 4) : 5'(i + 5);
  endfunction
  task automatic tally(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_vec(input logic [4:0] g);
    tally(exp_v.size() > 0 && g === exp_v.pop_front(), "vector taken");
  endtask
  task automatic chk_b(input logic [1:0] g);
    tally(exp_b.size() > 0 && g === exp_b.pop_front(), "write response");
  endtask
  task automatic chk_r(input logic [33:0] g);
    tally(exp_r.size() > 0 && g === exp_r.pop_front(), "read data");
  endtask
  always @(posedge mclk) begin
    if (!rst && irq_ack && irq_req) chk_vec(irq_vector);
    if (!rst && s_axi_bvalid && s_axi_bready) chk_b(s_axi_bresp);
    if (!rst && s_axi_rvalid && s_axi_rready) chk_r({s_axi_rresp, s_axi_rdata});
  end

  // ---------------------------------------------------------------
  // Bus master and helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    exp_b.push_back(r);
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    repeat (rnd() % 3) @(posedge mclk);
    s_axi_bready <= 1'h1;
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat (rnd() % 3) @(posedge mclk);
    s_axi_rready <= 1'h1;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic pulse(input logic [13:0] m);
    periph_event <= m;
    @(posedge mclk);
    periph_event <= 14'h0000;
    repeat (12) @(posedge mclk);
  endtask
  task automatic setup(input logic [31:0] ctl);
    cpu_global_ie <= 1'h0;
    wr(MCU_CONTROL_OFS, ctl, RESP_OKAY);
    wr(IRQ_FLAG_OFS, 32'h0007FFFE, RESP_OKAY);
    cpu_global_ie <= 1'h1;
  endtask
  task automatic give_verdict;
    fails += exp_v.size() + exp_b.size() + exp_r.size();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    $display("CHECK FAILED at %0t: watchdog", $time);
    fails++;
    give_verdict;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    mclk = 0; rst = 1; ce = 1; ack_en = 1; ack_wait = 2'h1; seed = 32'h375A2C4E;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, periph_event, nvm_ready} = '0;
    s_axi_wstrb = 4'hF; ext_irq_line0 = 1; ext_irq_line1 = 1; pin_change_sources = 16'hFFFF;
    cpu_global_ie = 0; fails = 0; total_checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(IRQ_STATUS_OFS, 32'h000000C0, RESP_OKAY);
    rd(MCU_CONTROL_OFS, 32'h0, RESP_OKAY);
    rd(PIN_CHANGE_MASK_OFS, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
    wr(IRQ_ENABLE_OFS, 32'hFFFFFFFF, RESP_OKAY);
    rd(IRQ_ENABLE_OFS, 32'h0007FFFE, RESP_OKAY);
    $display("registers done");
    cpu_global_ie <= 1'h1;
    for (int i = 0; i < 14; i++) begin
      exp_v.push_back(ev_vec(i));
      pulse(14'(1 << i));
    end
    ack_wait <= 2'(rnd());
    for (int i = 0; i < 14; i++) exp_v.push_back(ev_vec(i));
    pulse(14'h3FFF);
    // Slowest core needs six cycles per vector, fourteen vectors queued
    repeat (100) @(posedge mclk);
    $display("vectors done");
    cpu_global_ie <= 1'h0;
    pulse(14'h2000);
    rd(IRQ_FLAG_OFS, 32'h00040000, RESP_OKAY);
    wr(IRQ_FLAG_OFS, 32'h00040000, RESP_OKAY);
    rd(IRQ_FLAG_OFS, 32'h0, RESP_OKAY);
    exp_v.push_back(T1_MATCH_A_VECTOR);
    pulse(14'h0001);
    cpu_global_ie <= 1'h1;
    repeat (12) @(posedge mclk);
    $display("gating done");
    setup(32'h0000000E);
    exp_v.push_back(EXT_LINE0_VECTOR);
    ext_irq_line0 <= 1'h0;
    repeat (12) @(posedge mclk);
    ext_irq_line1 <= 1'h0;
    repeat (12) @(posedge mclk);
    exp_v.push_back(EXT_LINE1_VECTOR);
    ext_irq_line1 <= 1'h1;
    repeat (12) @(posedge mclk);
    ext_irq_line0 <= 1'h1;
    repeat (12) @(posedge mclk);
    setup(32'h00000005);
    exp_v.push_back(EXT_LINE0_VECTOR);
    ext_irq_line0 <= 1'h0;
    repeat (12) @(posedge mclk);
    exp_v.push_back(EXT_LINE0_VECTOR);
    ext_irq_line0 <= 1'h1;
    repeat (12) @(posedge mclk);
    $display("edges done");
    ack_en <= 1'h0;
    setup(32'h0);
    ext_irq_line0 <= 1'h0;
    repeat (10) @(posedge mclk);
    rd(IRQ_STATUS_OFS, 32'h000000A1, RESP_OKAY);
    repeat (20) @(posedge mclk);
    rd(IRQ_STATUS_OFS, 32'h000000A1, RESP_OKAY);
    // Clock enable low freezes the synchronisers, so the release stays unseen
    ce <= 1'h0;
    ext_irq_line0 <= 1'h1;
    repeat (6) @(posedge mclk);
    ce <= 1'h1;
    rd(IRQ_STATUS_OFS, 32'h000000A1, RESP_OKAY);
    nvm_ready <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(IRQ_STATUS_OFS, 32'h000000E9, RESP_OKAY);
    nvm_ready <= 1'h0;
    repeat (4) @(posedge mclk);
    // Vector field keeps the last one offered once nothing is pending
    rd(IRQ_STATUS_OFS, 32'h000000C9, RESP_OKAY);
    ack_en <= 1'h1;
    $display("levels done");
    pmask = 16'(rnd());
    cpu_global_ie <= 1'h0;
    wr(PIN_CHANGE_MASK_OFS, {16'h0, pmask}, RESP_OKAY);
    rd(PIN_CHANGE_MASK_OFS, {16'h0, pmask}, RESP_OKAY);
    setup(32'h0);
    for (int k = 0; k < 10; k++) begin
      automatic int p = rnd() % 16;
      if (pmask[p]) exp_v.push_back(PIN_CHANGE_VECTOR);
      pin_change_sources[p] <= ~pin_change_sources[p];
      repeat (14) @(posedge mclk);
    end
    $display("pin change done");
    give_verdict;
  end
endmodule
